// ==== src/pmc_power_mode_control.sv ====
`timescale 1ns/1ps

// Functional notes
// - Eight-bit power control register, index 87h
// - Top bit doubles UART rate, modes 1-3
// - Frame-error select steers serial control bit 7
// - Power-on flag set by hardware, software clears
// - Two general flags, software only, no effect
// - Power-down stops oscillator, CPU and peripherals
// - Any of four wake pins ends power-down
// - After pin wake, resume interrupted program
// - Idle write is last; CPU clock gated
// - Idle keeps all CPU state unchanged
// - Idle holds port pins at entry level
// - Idle holds both strobes high
// - Timers and UART keep running in idle
// - Enabled interrupt clears idle select bit
// - After idle interrupt, continue next instruction
// - Power-down write is last; state retained
// - Pin wake waits 32768 oscillator clocks
// - Reset pin wake restarts at zero
module pmc_power_mode_control #(
  parameter int unsigned WARMUP_CYCLES = pmc_pkg::WARMUP_CYCLES
) (
  // Clock, reset, clock enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pmc_pkg::ADDR_W-1:0] paddr,
  input wire logic [pmc_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [pmc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Wake and reset sources
  input wire logic wake_pin_zero_n,
  input wire logic wake_pin_one_n,
  input wire logic wake_pin_two_n,
  input wire logic wake_pin_three_n,
  input wire logic irq_request,
  input wire logic reset_pin,
  input wire logic power_on_event,
  // Clock gating and hold controls
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_en,
  output logic port_hold,
  output logic strobe_hold_high,
  output logic core_reset,
  output logic wake_resume,
  // UART options
  output logic uart_rate_double,
  output logic frame_error_select
);

  logic [pmc_pkg::REG_W-1:0] ctrl_q;
  logic [pmc_pkg::REG_W-1:0] ctrl_d;
  pmc_pkg::pmc_mode_e mode_q;
  pmc_pkg::pmc_mode_e mode_d;
  logic pready_q;
  logic pslverr_q;
  logic [pmc_pkg::DATA_W-1:0] prdata_q;
  logic cpu_clk_en_q;
  logic periph_clk_en_q;
  logic osc_en_q;
  logic port_hold_q;
  logic strobe_hold_q;
  logic core_reset_q;
  logic wake_resume_q;
  logic settle_busy;
  logic settle_done;

  // APB decode
  wire bus_setup = psel && !penable;
  wire bus_done = psel && penable && pready_q;
  wire hit_ctrl = pmc_pkg::addr_hit(paddr, pmc_pkg::PWR_CTRL_ADDR);
  wire hit_stat = pmc_pkg::addr_hit(paddr, pmc_pkg::MODE_STAT_ADDR);
  wire hit_any = hit_ctrl || hit_stat;
  wire wr_ctrl = bus_done && pwrite && hit_ctrl && pstrb[0];
  wire [pmc_pkg::REG_W-1:0] wdata = pwdata[pmc_pkg::REG_W-1:0] & pmc_pkg::PWR_CTRL_WMASK;
  wire wr_pdown = wr_ctrl && wdata[pmc_pkg::BIT_PDOWN_SEL];
  wire wr_sleep = wr_ctrl && wdata[pmc_pkg::BIT_SLEEP_SEL] && !wdata[pmc_pkg::BIT_PDOWN_SEL];

  // Mode status word
  wire [pmc_pkg::REG_W-1:0] stat_word = pmc_pkg::REG_W'(
    ((mode_q == pmc_pkg::MODE_IDLE) << pmc_pkg::STAT_IDLE) |
    ((mode_q == pmc_pkg::MODE_PDOWN) << pmc_pkg::STAT_PDOWN) |
    (settle_busy << pmc_pkg::STAT_WARMUP) |
    (core_reset_q << pmc_pkg::STAT_RESET_PIN));
  wire [pmc_pkg::REG_W-1:0] read_byte = hit_ctrl ? ctrl_q : (hit_stat ? stat_word : '0);

  wire pin_wake = !wake_pin_zero_n || !wake_pin_one_n || !wake_pin_two_n || !wake_pin_three_n;
  wire in_run = (mode_q == pmc_pkg::MODE_RUN);
  wire in_idle = (mode_q == pmc_pkg::MODE_IDLE);
  wire in_pdown = (mode_q == pmc_pkg::MODE_PDOWN);
  wire in_warm = (mode_q == pmc_pkg::MODE_WARMUP);
  wire idle_exit = in_idle && irq_request;
  wire warm_start = in_pdown && pin_wake;
  wire warm_end = in_warm && settle_done;

  // Mode sequencing
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      pmc_pkg::MODE_RUN: begin
        if (wr_pdown) begin
          mode_d = pmc_pkg::MODE_PDOWN;
        end else if (wr_sleep) begin
          mode_d = pmc_pkg::MODE_IDLE;
        end
      end
      pmc_pkg::MODE_IDLE: begin
        if (irq_request) begin
          mode_d = pmc_pkg::MODE_RUN;
        end
      end
      pmc_pkg::MODE_PDOWN: begin
        if (pin_wake) begin
          mode_d = pmc_pkg::MODE_WARMUP;
        end
      end
      pmc_pkg::MODE_WARMUP: begin
        if (settle_done) begin
          mode_d = pmc_pkg::MODE_RUN;
        end
      end
    endcase
    // reset pin forces run from zero
    if (reset_pin) begin
      mode_d = pmc_pkg::MODE_RUN;
    end
  end

  // Control register next value
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d[pmc_pkg::BIT_RATE_DOUBLE] = wdata[pmc_pkg::BIT_RATE_DOUBLE];
      ctrl_d[pmc_pkg::BIT_FRAME_ERR_SEL] = wdata[pmc_pkg::BIT_FRAME_ERR_SEL];
      ctrl_d[pmc_pkg::BIT_POWER_ON] = wdata[pmc_pkg::BIT_POWER_ON];
      ctrl_d[pmc_pkg::BIT_GEN_ONE] = wdata[pmc_pkg::BIT_GEN_ONE];
      ctrl_d[pmc_pkg::BIT_GEN_ZERO] = wdata[pmc_pkg::BIT_GEN_ZERO];
      // Select bits only take effect from run
      if (in_run) begin
        ctrl_d[pmc_pkg::BIT_PDOWN_SEL] = wdata[pmc_pkg::BIT_PDOWN_SEL];
        // idle bit dropped when power-down set
        ctrl_d[pmc_pkg::BIT_SLEEP_SEL] = wr_sleep;
      end
    end
    if (power_on_event) begin
      ctrl_d[pmc_pkg::BIT_POWER_ON] = 1'b1;
    end
    if (idle_exit) begin
      ctrl_d[pmc_pkg::BIT_SLEEP_SEL] = 1'b0;
    end
    if (warm_end) begin
      ctrl_d[pmc_pkg::BIT_PDOWN_SEL] = 1'b0;
    end
    if (reset_pin) begin
      ctrl_d[pmc_pkg::BIT_PDOWN_SEL] = 1'b0;
      ctrl_d[pmc_pkg::BIT_SLEEP_SEL] = 1'b0;
    end
  end

  // Gate and hold controls from next mode
  wire run_d = (mode_d == pmc_pkg::MODE_RUN);
  wire idle_d = (mode_d == pmc_pkg::MODE_IDLE);
  wire osc_d = (mode_d != pmc_pkg::MODE_PDOWN);
  // peripherals clocked in run and idle
  wire periph_d = run_d || idle_d;
  wire cpu_d = run_d && !reset_pin;
  wire hold_d = !run_d;

  pmc_settle_counter #(
    .LIMIT(WARMUP_CYCLES)
  ) u_settle (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .start(warm_start && !reset_pin),
    .abort(reset_pin),
    .busy_q(settle_busy),
    .done_q(settle_done)
  );

  // APB answer: no wait state, answer registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else if (clk_en) begin
      pready_q <= bus_setup;
      pslverr_q <= bus_setup && !hit_any;
      prdata_q <= bus_setup ? {{(pmc_pkg::DATA_W - pmc_pkg::REG_W){1'b0}}, read_byte} : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= pmc_pkg::PWR_CTRL_RESET;
      mode_q <= pmc_pkg::MODE_RUN;
    end else if (clk_en) begin
      ctrl_q <= ctrl_d;
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en_q <= 1'b1;
      periph_clk_en_q <= 1'b1;
      osc_en_q <= 1'b1;
      port_hold_q <= 1'b0;
      strobe_hold_q <= 1'b0;
      core_reset_q <= 1'b0;
      wake_resume_q <= 1'b0;
    end else if (clk_en) begin
      cpu_clk_en_q <= cpu_d;
      periph_clk_en_q <= periph_d;
      osc_en_q <= osc_d;
      port_hold_q <= hold_d;
      strobe_hold_q <= hold_d;
      core_reset_q <= reset_pin;
      wake_resume_q <= warm_end && !reset_pin;
    end
  end

  // Output drive
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cpu_clk_en = cpu_clk_en_q;
  assign periph_clk_en = periph_clk_en_q;
  assign osc_en = osc_en_q;
  assign port_hold = port_hold_q;
  assign strobe_hold_high = strobe_hold_q;
  assign core_reset = core_reset_q;
  assign wake_resume = wake_resume_q;
  assign uart_rate_double = ctrl_q[pmc_pkg::BIT_RATE_DOUBLE];
  assign frame_error_select = ctrl_q[pmc_pkg::BIT_FRAME_ERR_SEL];

endmodule

// ==== common/pmc_pkg.sv ====
package pmc_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;

  // Register indices; byte address is four times the index
  localparam logic [7:0] PWR_CTRL_INDEX = 8'h87;
  localparam logic [7:0] MODE_STAT_INDEX = 8'h88;
  localparam logic [ADDR_W-1:0] PWR_CTRL_ADDR = {2'h0, PWR_CTRL_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] MODE_STAT_ADDR = {2'h0, MODE_STAT_INDEX, 2'h0};

  // Power control field positions
  localparam int unsigned BIT_RATE_DOUBLE = 7;
  localparam int unsigned BIT_FRAME_ERR_SEL = 6;
  localparam int unsigned BIT_POWER_ON = 4;
  localparam int unsigned BIT_GEN_ONE = 3;
  localparam int unsigned BIT_GEN_ZERO = 2;
  localparam int unsigned BIT_PDOWN_SEL = 1;
  localparam int unsigned BIT_SLEEP_SEL = 0;

  // Reset value: power-on flag set, all else clear; bit 5 reads zero
  localparam logic [REG_W-1:0] PWR_CTRL_RESET = 8'h10;
  localparam logic [REG_W-1:0] PWR_CTRL_WMASK = 8'hdf;

  // Mode status field positions
  localparam int unsigned STAT_IDLE = 0;
  localparam int unsigned STAT_PDOWN = 1;
  localparam int unsigned STAT_WARMUP = 2;
  localparam int unsigned STAT_RESET_PIN = 3;

  // Oscillator settle after a pin wake, in oscillator clocks (one per pclk)
  localparam int unsigned WARMUP_OSC_CLOCKS = 32768;
  localparam int unsigned OSC_CLOCKS_PER_PCLK = 1;
  localparam int unsigned WARMUP_CYCLES = WARMUP_OSC_CLOCKS / OSC_CLOCKS_PER_PCLK;
  localparam int unsigned WARMUP_CNT_W = 17;

  // Reset pin hold the far side must give: two machine cycles of 12 clocks
  localparam int unsigned RESET_HOLD_MACHINE_CYCLES = 2;
  localparam int unsigned CLOCKS_PER_MACHINE_CYCLE = 12;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_IDLE,
    MODE_PDOWN,
    MODE_WARMUP
  } pmc_mode_e;

  // Word select of a register index
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] reg_addr);
    addr_hit = (addr == reg_addr);
  endfunction

endpackage

// ==== src/pmc_settle_counter.sv ====
`timescale 1ns/1ps

module pmc_settle_counter #(
  parameter int unsigned LIMIT = pmc_pkg::WARMUP_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Control
  input wire logic start,
  input wire logic abort,
  // Status
  output logic busy_q,
  output logic done_q
);

  localparam logic [pmc_pkg::WARMUP_CNT_W-1:0] LAST =
    pmc_pkg::WARMUP_CNT_W'(LIMIT - 1);

  logic [pmc_pkg::WARMUP_CNT_W-1:0] count_q;
  logic [pmc_pkg::WARMUP_CNT_W-1:0] count_d;
  logic busy_d;
  logic done_d;
  wire at_last = busy_q && (count_q == LAST);

  assign count_d = (start || !busy_q) ? '0 : count_q + 1'b1;
  assign busy_d = abort ? 1'b0 : (start ? 1'b1 : (busy_q && !at_last));
  assign done_d = !abort && at_last;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (clk_en) begin
      count_q <= count_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

endmodule

// ==== verif/pmc_core_model.sv ====
`timescale 1ns/1ps
module pmc_core_model (
  // Clock and bench commands
  input wire logic pclk,
  input wire logic [3:0] pin_go,
  input wire logic irq_go,
  input wire logic rst_go,
  // Device status
  input wire logic cpu_clk_en,
  input wire logic wake_resume,
  // Pins towards the device
  output logic [3:0] pin_n,
  output logic irq_request,
  output logic reset_pin
);
  int hold_q;
  initial begin
    pin_n = 4'hf;
    irq_request = 1'b0;
    hold_q = 0;
  end
  // Wake pin stays low until the core resumes
  always @(posedge pclk) begin
    if (pin_go != 4'h0) begin
      pin_n <= ~pin_go;
    end else if (wake_resume) begin
      pin_n <= 4'hf;
    end
    irq_request <= irq_go || (irq_request && !cpu_clk_en);
    hold_q <= rst_go ? pmc_pkg::RESET_HOLD_MACHINE_CYCLES * pmc_pkg::CLOCKS_PER_MACHINE_CYCLE
      : (hold_q > 0 ? hold_q - 1 : 0);
  end
  assign reset_pin = hold_q > 0;
endmodule

// ==== verif/pmc_mode_monitor.sv ====
`timescale 1ns/1ps
module pmc_mode_monitor #(
  parameter int unsigned WARMUP_CYCLES = 8
) (
  // Clock and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  // Wake sources
  input wire logic wake_pin_zero_n,
  input wire logic wake_pin_one_n,
  input wire logic wake_pin_two_n,
  input wire logic wake_pin_three_n,
  input wire logic irq_request,
  input wire logic reset_pin,
  // Mode outputs
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic osc_en,
  input wire logic port_hold,
  input wire logic strobe_hold_high,
  input wire logic core_reset,
  input wire logic wake_resume,
  input wire logic uart_rate_double
);
  int cnt_q;
  logic warm_q;
  wire logic wr_c = psel && penable && pready && pwrite && pstrb[0] && paddr == 12'h21c;
  wire logic pin_lo = !(wake_pin_zero_n && wake_pin_one_n && wake_pin_two_n && wake_pin_three_n);
  wire logic run_ok = cpu_clk_en && !reset_pin;
  // Cycles spent since a pin woke the oscillator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warm_q <= 1'b0;
      cnt_q <= 0;
    end else begin
      warm_q <= (warm_q || (!osc_en && pin_lo)) && !wake_resume && !reset_pin;
      cnt_q <= warm_q ? cnt_q + 1 : 0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence answer_s; pready ##1 !pready; endsequence
  rdy_pulse_a:
    assert property (setup_s |=> answer_s) else $error("bad pready pulse");
  uart_bits_a:
    assert property (wr_c |=> uart_rate_double == $past(pwdata[7])) else $error("bad rate bit");
  idle_in_a:
    assert property (wr_c && run_ok && pwdata[1:0] == 2'b01 |-> ##[1:2] (!cpu_clk_en
      && port_hold && strobe_hold_high && periph_clk_en && osc_en)) else $error("bad idle");
  pdown_in_a:
    assert property (wr_c && run_ok && pwdata[1] |-> ##[1:2] (!cpu_clk_en && !periph_clk_en
      && !osc_en)) else $error("bad power-down");
  idle_out_a:
    assert property (irq_request && !cpu_clk_en && periph_clk_en && osc_en && !reset_pin
      |-> ##[1:2] cpu_clk_en) else $error("idle not left");
  pin_wake_a:
    assert property (!osc_en && pin_lo && !reset_pin |=> osc_en && !cpu_clk_en)
      else $error("pin wake missed");
  warm_len_a:
    assert property (warm_q |-> cnt_q <= WARMUP_CYCLES + 4 && (!wake_resume
      || cnt_q >= WARMUP_CYCLES)) else $error("bad warm-up length");
  core_rst_a:
    assert property (reset_pin |-> ##[1:2] core_reset) else $error("core reset missing");
endmodule
bind pmc_power_mode_control pmc_mode_monitor #(.WARMUP_CYCLES(WARMUP_CYCLES)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .wake_pin_zero_n(wake_pin_zero_n), .wake_pin_one_n(wake_pin_one_n),
  .wake_pin_two_n(wake_pin_two_n), .wake_pin_three_n(wake_pin_three_n),
  .irq_request(irq_request), .reset_pin(reset_pin), .cpu_clk_en(cpu_clk_en),
  .periph_clk_en(periph_clk_en), .osc_en(osc_en), .port_hold(port_hold),
  .strobe_hold_high(strobe_hold_high), .core_reset(core_reset),
  .wake_resume(wake_resume), .uart_rate_double(uart_rate_double));

// ==== verif/tb_power_mode_control.sv ====
`timescale 1ns/1ps
module tb_power_mode_control;
  logic pclk, presetn, psel, penable, pwrite, pon, irq_go, rst_go;
  logic pready, pslverr, err, irq_request, reset_pin, wake_resume, core_reset;
  logic cpu_clk_en, periph_clk_en, osc_en, port_hold, strobe_hold_high, urd, fes;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pin_go, pin_n, strb;
  int n_mismatch = 0;
  int n_checks = 0;
  pmc_power_mode_control #(.WARMUP_CYCLES(8)) u_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wake_pin_zero_n(pin_n[0]),
    .wake_pin_one_n(pin_n[1]), .wake_pin_two_n(pin_n[2]), .wake_pin_three_n(pin_n[3]),
    .irq_request(irq_request), .reset_pin(reset_pin), .power_on_event(pon),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_en(osc_en),
    .port_hold(port_hold), .strobe_hold_high(strobe_hold_high), .core_reset(core_reset),
    .wake_resume(wake_resume), .uart_rate_double(urd), .frame_error_select(fes));
  pmc_core_model u_core (
    .pclk(pclk), .pin_go(pin_go), .irq_go(irq_go), .rst_go(rst_go),
    .cpu_clk_en(cpu_clk_en), .wake_resume(wake_resume), .pin_n(pin_n),
    .irq_request(irq_request), .reset_pin(reset_pin));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task final_report;
    if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tmo;
    n_mismatch++;
    $display("mismatch %0t wait timed out", $time);
    final_report;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      if (++i > 20) tmo;
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] v);
    apb(1'b1, pmc_pkg::PWR_CTRL_ADDR, {24'h0, v});
  endtask
  task rdc(input logic [7:0] e);
    apb(1'b0, pmc_pkg::PWR_CTRL_ADDR, 32'h0);
    chk(rd, {24'h0, e});
  endtask
  task settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task t_regs;
    rdc(8'h10);
    wr(8'hcc);
    rdc(8'hcc);
    chk({urd, fes}, 2'b11);
    pon <= 1'b1;
    @(posedge pclk);
    pon <= 1'b0;
    rdc(8'hdc);
    strb <= 4'he;
    wr(8'h00);
    strb <= 4'hf;
    rdc(8'hdc);
    wr(8'h0c);
    settle(0);
    chk({urd, fes}, 2'b00);
    apb(1'b1, pmc_pkg::MODE_STAT_ADDR, 32'hff);
    chk(err, 1'b0);
    apb(1'b0, pmc_pkg::MODE_STAT_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
  endtask
  task t_idle;
    wr(8'h0d);
    settle(2);
    chk({cpu_clk_en, periph_clk_en, osc_en}, 3'b011);
    chk({port_hold, strobe_hold_high}, 2'b11);
    apb(1'b0, pmc_pkg::MODE_STAT_ADDR, 32'h0);
    chk(rd, 32'h1);
    @(posedge pclk);
    irq_go <= 1'b1;
    @(posedge pclk);
    irq_go <= 1'b0;
    settle(3);
    chk({cpu_clk_en, port_hold, strobe_hold_high}, 3'b100);
    rdc(8'h0c);
  endtask
  task t_pdown(input int p);
    int i;
    wr(8'h0f);
    settle(2);
    chk({cpu_clk_en, periph_clk_en, osc_en}, 3'b000);
    rdc(8'h0e);
    apb(1'b0, pmc_pkg::MODE_STAT_ADDR, 32'h0);
    chk(rd, 32'h2);
    @(posedge pclk);
    pin_go <= 4'h1 << p;
    @(posedge pclk);
    pin_go <= 4'h0;
    i = 0;
    while (wake_resume !== 1'b1) begin
      if (++i > 100) tmo;
      @(negedge pclk);
    end
    chk(i >= 8, 1);
    chk(i <= 12, 1);
    settle(1);
    chk({cpu_clk_en, osc_en, port_hold}, 3'b110);
    rdc(8'h0c);
  endtask
  task t_rstpin;
    wr(8'h0e);
    settle(2);
    @(posedge pclk);
    rst_go <= 1'b1;
    @(posedge pclk);
    rst_go <= 1'b0;
    settle(3);
    chk({cpu_clk_en, osc_en, core_reset}, 3'b011);
    settle(27);
    chk({cpu_clk_en, osc_en, core_reset}, 3'b110);
    rdc(8'h0c);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, pon, irq_go, rst_go} = 7'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pin_go = 4'h0;
    strb = 4'hf;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_idle;
    for (int p = 0; p < 4; p++) t_pdown(p);
    t_rstpin;
    final_report;
  end
endmodule
